// ---- include/ssi_params.svh ----
`ifndef SSI_PARAMS_SVH
`define SSI_PARAMS_SVH

// Register byte offsets
`define SSI_OFF_INT_ENABLE 32'h0000_00DC
`define SSI_OFF_INT_STATUS 32'h0000_010C
`define SSI_OFF_SEC_STATUS 32'h0000_0114
`define SSI_OFF_PRI_STATUS 32'h0000_0130

// Reset values
`define SSI_RST_WORD 32'h0000_0000

// Secondary status field positions
`define SSI_SEC_VID2 12
`define SSI_SEC_VID1 11
`define SSI_SEC_AIN2 10
`define SSI_SEC_AOUT2 9
`define SSI_SEC_AIN1 8
`define SSI_SEC_AOUT1 7
`define SSI_SEC_RSVD 6
`define SSI_SEC_VGATE 5
`define SSI_SEC_LGATE 4
`define SSI_SEC_EC5 3
`define SSI_SEC_EC4 2
`define SSI_SEC_EC2 1
`define SSI_SEC_EC1 0

// Interrupt status/enable positions handled inside this block
`define SSI_INT_AUDIO_FIFO 11
`define SSI_INT_VIDEO_FIFO 9
`define SSI_INT_COUNTERS 2

// Primary status position of the combined counter flag
`define SSI_PRI_COUNTERS 2

`endif

// ---- include/ssi_pkg.sv ----
package ssi_pkg;

  // FIFO error event pulses
  typedef struct packed {
    logic video2;
    logic video1;
    logic audio_in2;
    logic audio_out2;
    logic audio_in1;
    logic audio_out1;
  } ssi_fifo_err_s;

  // DMA base reload and channel restart pulses
  typedef struct packed {
    logic video2_reload;
    logic video1_reload;
    logic audio_in2_restart;
    logic audio_out2_restart;
    logic audio_in1_restart;
    logic audio_out1_restart;
  } ssi_dma_clr_s;

  // Event counter threshold pulses
  typedef struct packed {
    logic cnt5;
    logic cnt4;
    logic cnt2;
    logic cnt1;
  } ssi_cnt_hit_s;

endpackage

// ---- rtl/ssi_status_irq.sv ----
// What this block does
// - Video FIFO 2 error sets bit 12; reload or video FIFO write-one clears it.
// - Video FIFO 1 overflow sets bit 11; reload or video FIFO write-one clears it.
// - Audio in FIFO 2 underflow sets bit 10; restart or audio write-one clears it.
// - Audio out FIFO 2 overflow sets bit 9; restart or audio write-one clears it.
// - Audio in FIFO 1 underflow sets bit 8; restart or audio write-one clears it.
// - Audio out FIFO 1 overflow sets bit 7; restart or audio write-one clears it.
// - Bit 5 mirrors the live vertical gate; bit 6 is reserved.
// - Bit 4 mirrors the live line qualifier gate.
// - Counter 5 threshold sets bit 3 until combined counter write-one.
// - Counter 4 threshold sets bit 2, cleared only by combined counter write-one.
// - Counter 2 threshold sets bit 1, cleared only by combined counter write-one.
// - Counter 1 threshold sets bit 0, cleared only by combined counter write-one.
// - 32-bit read/write enable register; bits 31..29 enable bus and parity errors.
// - Enable bits 28,27 sequencer command; 26,25 sequencer late.
// - Enable bits 24,23 sequencer error; 22,21 timeout; 20 upload.
// - Enable bits 19,18 debug interface; 17,16 two-wire status and error.
// - Enable bits 15..12 audio DMA address protection, in listed order.
// - Enable bit 11 audio FIFO, 10 video protection, 9 video FIFO.
// - Enable bits 8 and 7 field identifier of ports A and B.
// - Enable bits 6..3 general purpose pins 3..0.
// - Enable bit 2 combined counters, bit 1 counter 3, bit 0 counter 0.
// - Interrupt status register mirrors enable positions; bit 2 combined counters.
// - Primary combined counter bit follows counter 5, 4, 2, 1 flags.
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/10ps
`include "ssi_params.svh"
module ssi_status_irq (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire ssi_pkg::ssi_fifo_err_s fifo_err_i,
  input wire ssi_pkg::ssi_dma_clr_s dma_clr_i,
  input wire ssi_pkg::ssi_cnt_hit_s cnt_hit_i,
  input wire logic vertical_gate_i,
  input wire logic line_gate_i,
  input wire logic [31:0] irq_src_i,
  output logic combined_counter_status_o,
  output logic irq_o
);

  // Sticky flag: set wins over clear
  function automatic logic sticky(input logic cur, input logic set, input logic clr);
    sticky = set | (cur & ~clr);
  endfunction

  // Byte enables widened to a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  logic [31:0] int_enable;
  logic [31:0] interrupt_status_register;
  logic video_fifo2_error_flag;
  logic video_fifo1_overflow_flag;
  logic audio_in_fifo2_underflow_flag;
  logic audio_out_fifo2_overflow_flag;
  logic audio_in_fifo1_underflow_flag;
  logic audio_out_fifo1_overflow_flag;
  logic counter5_threshold_flag;
  logic counter4_threshold_flag;
  logic counter2_threshold_flag;
  logic counter1_threshold_flag;

  // Bus decode
  wire req = cyc_i & stb_i;
  wire first = req & ~ack_o;
  wire wr_take = req & ack_o & we_i;
  wire hit_ier = adr_i == `SSI_OFF_INT_ENABLE;
  wire hit_ist = adr_i == `SSI_OFF_INT_STATUS;
  wire hit_sec = adr_i == `SSI_OFF_SEC_STATUS;
  wire hit_pri = adr_i == `SSI_OFF_PRI_STATUS;
  wire [31:0] wmask = lane_mask(sel_i);
  wire [31:0] ier_wmask = (wr_take & hit_ier) ? wmask : 32'h0000_0000;
  wire [31:0] w1c = (wr_take & hit_ist) ? (dat_i & wmask) : 32'h0000_0000;

  // Write-one clears of the grouped status bits
  wire clr_video = w1c[`SSI_INT_VIDEO_FIFO];
  wire clr_audio = w1c[`SSI_INT_AUDIO_FIFO];
  wire clr_count = w1c[`SSI_INT_COUNTERS];

  // Grouped events raising the interrupt status bits
  wire ev_video = fifo_err_i.video2 | fifo_err_i.video1;
  wire ev_audio = fifo_err_i.audio_in2 | fifo_err_i.audio_out2 |
                  fifo_err_i.audio_in1 | fifo_err_i.audio_out1;
  wire ev_count = cnt_hit_i.cnt5 | cnt_hit_i.cnt4 | cnt_hit_i.cnt2 | cnt_hit_i.cnt1;

  // Status set vector: grouped bits come from this block, the rest from sources
  wire [31:0] grp_pos = (32'h0000_0001 << `SSI_INT_AUDIO_FIFO) |
                        (32'h0000_0001 << `SSI_INT_VIDEO_FIFO) |
                        (32'h0000_0001 << `SSI_INT_COUNTERS);
  wire [31:0] grp_set = ({31'h0000_0000, ev_audio} << `SSI_INT_AUDIO_FIFO) |
                        ({31'h0000_0000, ev_video} << `SSI_INT_VIDEO_FIFO) |
                        ({31'h0000_0000, ev_count} << `SSI_INT_COUNTERS);
  wire [31:0] ist_set = (irq_src_i & ~grp_pos) | grp_set;
  wire [31:0] next_ist = ist_set | (interrupt_status_register & ~w1c);

  // Enable register update under byte lanes
  wire [31:0] next_ier = (dat_i & ier_wmask) | (int_enable & ~ier_wmask);

  // Secondary status word
  wire [31:0] sec_word = {19'h0_0000,
                          video_fifo2_error_flag,
                          video_fifo1_overflow_flag,
                          audio_in_fifo2_underflow_flag,
                          audio_out_fifo2_overflow_flag,
                          audio_in_fifo1_underflow_flag,
                          audio_out_fifo1_overflow_flag,
                          1'b0,
                          vertical_gate_i,
                          line_gate_i,
                          counter5_threshold_flag,
                          counter4_threshold_flag,
                          counter2_threshold_flag,
                          counter1_threshold_flag};

  // Combined counter flag for the primary status view
  wire combined_counter_status = counter5_threshold_flag | counter4_threshold_flag |
                                 counter2_threshold_flag | counter1_threshold_flag;
  wire [31:0] pri_word = {29'h0000_0000, combined_counter_status, 2'b00};

  // Read selection; unmapped reads return zero
  wire [31:0] rdata = hit_ier ? int_enable :
                      hit_ist ? interrupt_status_register :
                      hit_sec ? sec_word :
                      hit_pri ? pri_word : 32'h0000_0000;

  // Bus answer: one wait state, ack for one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= `SSI_RST_WORD;
    end else begin
      ack_o <= first;
      if (first) begin
        dat_o <= rdata;
      end
    end
  end

  // Enable and interrupt status registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_enable <= `SSI_RST_WORD;
      interrupt_status_register <= `SSI_RST_WORD;
    end else begin
      int_enable <= next_ier;
      interrupt_status_register <= next_ist;
    end
  end

  // Video FIFO flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      video_fifo2_error_flag <= 1'b0;
      video_fifo1_overflow_flag <= 1'b0;
    end else begin
      video_fifo2_error_flag <= sticky(video_fifo2_error_flag, fifo_err_i.video2,
                                       dma_clr_i.video2_reload | clr_video);
      video_fifo1_overflow_flag <= sticky(video_fifo1_overflow_flag, fifo_err_i.video1,
                                          dma_clr_i.video1_reload | clr_video);
    end
  end

  // Audio FIFO flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      audio_in_fifo2_underflow_flag <= 1'b0;
      audio_out_fifo2_overflow_flag <= 1'b0;
      audio_in_fifo1_underflow_flag <= 1'b0;
      audio_out_fifo1_overflow_flag <= 1'b0;
    end else begin
      audio_in_fifo2_underflow_flag <= sticky(audio_in_fifo2_underflow_flag, fifo_err_i.audio_in2,
                                              dma_clr_i.audio_in2_restart | clr_audio);
      audio_out_fifo2_overflow_flag <= sticky(audio_out_fifo2_overflow_flag, fifo_err_i.audio_out2,
                                              dma_clr_i.audio_out2_restart | clr_audio);
      audio_in_fifo1_underflow_flag <= sticky(audio_in_fifo1_underflow_flag, fifo_err_i.audio_in1,
                                              dma_clr_i.audio_in1_restart | clr_audio);
      audio_out_fifo1_overflow_flag <= sticky(audio_out_fifo1_overflow_flag, fifo_err_i.audio_out1,
                                              dma_clr_i.audio_out1_restart | clr_audio);
    end
  end

  // Event counter threshold flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      counter5_threshold_flag <= 1'b0;
      counter4_threshold_flag <= 1'b0;
      counter2_threshold_flag <= 1'b0;
      counter1_threshold_flag <= 1'b0;
    end else begin
      counter5_threshold_flag <= sticky(counter5_threshold_flag, cnt_hit_i.cnt5, clr_count);
      counter4_threshold_flag <= sticky(counter4_threshold_flag, cnt_hit_i.cnt4, clr_count);
      counter2_threshold_flag <= sticky(counter2_threshold_flag, cnt_hit_i.cnt2, clr_count);
      counter1_threshold_flag <= sticky(counter1_threshold_flag, cnt_hit_i.cnt1, clr_count);
    end
  end

  // Outputs
  assign combined_counter_status_o = combined_counter_status;
  assign irq_o = |(interrupt_status_register & int_enable);

  // Checks

  property p_vf2_set;
    @(posedge clk_i) disable iff (rst_i)
      fifo_err_i.video2 |=> video_fifo2_error_flag;
  endproperty
  a_vf2_set: assert property (p_vf2_set) else $error("video fifo 2 flag not set");

  property p_vf1_clear;
    @(posedge clk_i) disable iff (rst_i)
      (clr_video | dma_clr_i.video1_reload) && !fifo_err_i.video1 |=> !video_fifo1_overflow_flag;
  endproperty
  a_vf1_clear: assert property (p_vf1_clear) else $error("video fifo 1 flag not cleared");

  property p_ain2_restart;
    @(posedge clk_i) disable iff (rst_i)
      audio_in_fifo2_underflow_flag && dma_clr_i.audio_in2_restart && !fifo_err_i.audio_in2
      |=> !audio_in_fifo2_underflow_flag;
  endproperty
  a_ain2_restart: assert property (p_ain2_restart) else $error("audio in 2 not cleared");

  property p_aout1_set_wins;
    @(posedge clk_i) disable iff (rst_i)
      fifo_err_i.audio_out1 && clr_audio |=> audio_out_fifo1_overflow_flag &&
      interrupt_status_register[`SSI_INT_AUDIO_FIFO];
  endproperty
  a_aout1_set_wins: assert property (p_aout1_set_wins) else $error("audio out 1 set lost");

  property p_vgate_read;
    @(posedge clk_i) disable iff (rst_i)
      first && hit_sec |=> ack_o && dat_o[`SSI_SEC_VGATE] == $past(vertical_gate_i) &&
      !dat_o[`SSI_SEC_RSVD];
  endproperty
  a_vgate_read: assert property (p_vgate_read) else $error("vertical gate read wrong");

  property p_ec5_hold;
    @(posedge clk_i) disable iff (rst_i)
      counter5_threshold_flag && !clr_count |=> counter5_threshold_flag;
  endproperty
  a_ec5_hold: assert property (p_ec5_hold) else $error("counter 5 flag dropped");

  property p_ier_write;
    @(posedge clk_i) disable iff (rst_i)
      wr_take && hit_ier && sel_i == 4'hF |=> int_enable == $past(dat_i);
  endproperty
  a_ier_write: assert property (p_ier_write) else $error("enable write lost");

  property p_count_group;
    @(posedge clk_i) disable iff (rst_i)
      cnt_hit_i.cnt2 |=> interrupt_status_register[`SSI_INT_COUNTERS] && counter2_threshold_flag;
  endproperty
  a_count_group: assert property (p_count_group) else $error("combined status not set");

  property p_pri_counters;
    @(posedge clk_i) disable iff (rst_i)
      first && hit_pri |=> dat_o[`SSI_PRI_COUNTERS] == $past(combined_counter_status);
  endproperty
  a_pri_counters: assert property (p_pri_counters) else $error("primary counter bit wrong");

  property p_irq_raise;
    @(posedge clk_i) disable iff (rst_i)
      irq_src_i[31] && int_enable[31] && !(ier_wmask[31]) |=> irq_o;
  endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("irq not raised");

  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

  property p_unmapped_zero;
    @(posedge clk_i) disable iff (rst_i)
      first && !(hit_ier | hit_ist | hit_sec | hit_pri) |=> ack_o && dat_o == 32'h0000_0000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

  property p_vf2_clear;
    @(posedge clk_i) disable iff (rst_i)
      (dma_clr_i.video2_reload | clr_video) && !fifo_err_i.video2 |=> !video_fifo2_error_flag;
  endproperty
  a_vf2_clear: assert property (p_vf2_clear) else $error("video fifo 2 flag not cleared");

  property p_vf1_set;
    @(posedge clk_i) disable iff (rst_i)
      fifo_err_i.video1 |=> video_fifo1_overflow_flag;
  endproperty
  a_vf1_set: assert property (p_vf1_set) else $error("video fifo 1 flag not set");

  property p_ain2_clear;
    @(posedge clk_i) disable iff (rst_i)
      clr_audio && !fifo_err_i.audio_in2 |=> !audio_in_fifo2_underflow_flag;
  endproperty
  a_ain2_clear: assert property (p_ain2_clear) else $error("audio in 2 not cleared by write");

  property p_aout2_set;
    @(posedge clk_i) disable iff (rst_i)
      fifo_err_i.audio_out2 |=> audio_out_fifo2_overflow_flag &&
      interrupt_status_register[`SSI_INT_AUDIO_FIFO];
  endproperty
  a_aout2_set: assert property (p_aout2_set) else $error("audio out 2 flag not set");

  property p_ain1_restart;
    @(posedge clk_i) disable iff (rst_i)
      dma_clr_i.audio_in1_restart && !fifo_err_i.audio_in1 |=> !audio_in_fifo1_underflow_flag;
  endproperty
  a_ain1_restart: assert property (p_ain1_restart) else $error("audio in 1 not cleared");

  property p_aout1_clear;
    @(posedge clk_i) disable iff (rst_i)
      clr_audio && !fifo_err_i.audio_out1 |=> !audio_out_fifo1_overflow_flag;
  endproperty
  a_aout1_clear: assert property (p_aout1_clear) else $error("audio out 1 not cleared");

  property p_sec_upper_zero;
    @(posedge clk_i) disable iff (rst_i)
      first && hit_sec |=> dat_o[31:13] == 19'h0_0000;
  endproperty
  a_sec_upper_zero: assert property (p_sec_upper_zero) else $error("secondary upper bits set");

  property p_lgate_read;
    @(posedge clk_i) disable iff (rst_i)
      first && hit_sec |=> dat_o[`SSI_SEC_LGATE] == $past(line_gate_i);
  endproperty
  a_lgate_read: assert property (p_lgate_read) else $error("line gate read wrong");

  property p_ec4_clear;
    @(posedge clk_i) disable iff (rst_i)
      clr_count && !cnt_hit_i.cnt4 |=> !counter4_threshold_flag;
  endproperty
  a_ec4_clear: assert property (p_ec4_clear) else $error("counter 4 flag not cleared");

  property p_ec2_hold;
    @(posedge clk_i) disable iff (rst_i)
      counter2_threshold_flag && !clr_count |=> counter2_threshold_flag;
  endproperty
  a_ec2_hold: assert property (p_ec2_hold) else $error("counter 2 flag dropped");

  property p_ec1_set;
    @(posedge clk_i) disable iff (rst_i)
      cnt_hit_i.cnt1 |=> counter1_threshold_flag && combined_counter_status_o;
  endproperty
  a_ec1_set: assert property (p_ec1_set) else $error("counter 1 flag not set");

  property p_ier_hold;
    @(posedge clk_i) disable iff (rst_i)
      !(wr_take && hit_ier) |=> $stable(int_enable);
  endproperty
  a_ier_hold: assert property (p_ier_hold) else $error("enable changed without write");

  property p_ist_clear;
    @(posedge clk_i) disable iff (rst_i)
      w1c[31] && !irq_src_i[31] |=> !interrupt_status_register[31];
  endproperty
  a_ist_clear: assert property (p_ist_clear) else $error("status bit not cleared");

  property p_count_clear;
    @(posedge clk_i) disable iff (rst_i)
      clr_count && !ev_count |=> !combined_counter_status_o;
  endproperty
  a_count_clear: assert property (p_count_clear) else $error("combined counter not cleared");

  property p_irq_drop;
    @(posedge clk_i) disable iff (rst_i)
      irq_o && (w1c == 32'hFFFF_FFFF) && (irq_src_i == 32'h0000_0000) &&
      !ev_video && !ev_audio && !ev_count |=> !irq_o;
  endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("irq not dropped");

  property p_ack_answer;
    @(posedge clk_i) disable iff (rst_i)
      first |=> ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not acknowledged");

endmodule

// ---- bench/ssi_status_irq_bench.sv ----
`timescale 1ns/10ps
`include "ssi_params.svh"
module ssi_status_irq_bench;
  // Stimulus registers and design outputs
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [31:0] adr_i = 32'h0000_0000;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [3:0] sel_i = 4'h0;
  ssi_pkg::ssi_fifo_err_s fifo_err_i = '0;
  ssi_pkg::ssi_dma_clr_s dma_clr_i = '0;
  ssi_pkg::ssi_cnt_hit_s cnt_hit_i = '0;
  logic vertical_gate_i = 1'b0;
  logic line_gate_i = 1'b0;
  logic [31:0] irq_src_i = 32'h0000_0000;
  logic [31:0] dat_o;
  logic ack_o;
  logic combined_counter_status_o;
  logic irq_o;
  int errors = 0;
  int total_checks = 0;
  int unsigned m_ien = 0;
  int unsigned m_ist = 0;
  int unsigned m_sec = 0;
  logic [31:0] rd;
  logic [31:0] v;

  ssi_status_irq u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .fifo_err_i(fifo_err_i),
    .dma_clr_i(dma_clr_i), .cnt_hit_i(cnt_hit_i), .vertical_gate_i(vertical_gate_i),
    .line_gate_i(line_gate_i), .irq_src_i(irq_src_i),
    .combined_counter_status_o(combined_counter_status_o), .irq_o(irq_o)
  );

  // Clock at 25 MHz
  always #20 clk_i = ~clk_i;

  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Comparison with report
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Classic single Wishbone cycle, waits for ack with a bound
  task automatic wb(input bit w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      $display("unexpected ack expected 1 seen %b", ack_o);
    end
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  // Register write plus model update; write one clears status and linked flags
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] bm;
    logic [31:0] r;
    bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    wb(1'b1, a, d, s, r);
    if (a == `SSI_OFF_INT_ENABLE) m_ien = (m_ien & ~bm) | (d & bm);
    if (a == `SSI_OFF_INT_STATUS) begin
      m_ist = m_ist & ~(d & bm);
      if ((d & bm & 32'h0000_0200) != 0) m_sec = m_sec & ~32'h0000_1800;
      if ((d & bm & 32'h0000_0800) != 0) m_sec = m_sec & ~32'h0000_0780;
      if ((d & bm & 32'h0000_0004) != 0) m_sec = m_sec & ~32'h0000_000F;
    end
  endtask

  // One-cycle event pulses plus model update; set wins over clear
  task automatic ev(input logic [5:0] f, input logic [5:0] c, input logic [3:0] h, input logic [31:0] src);
    @(posedge clk_i);
    fifo_err_i <= f;
    dma_clr_i <= c;
    cnt_hit_i <= h;
    irq_src_i <= src;
    @(posedge clk_i);
    fifo_err_i <= '0;
    dma_clr_i <= '0;
    cnt_hit_i <= '0;
    irq_src_i <= 32'h0000_0000;
    m_sec = (m_sec & ~({19'h0, c, 7'h0})) | {19'h0, f, 7'h0} | {28'h0, h};
    m_ist = m_ist | (src & ~32'h0000_0A04);
    if (f[5:4] != 0) m_ist = m_ist | 32'h0000_0200;
    if (f[3:0] != 0) m_ist = m_ist | 32'h0000_0800;
    if (h != 0) m_ist = m_ist | 32'h0000_0004;
  endtask

  // Reads every view and compares it and the outputs with the model
  task automatic check_all();
    logic [31:0] r;
    wb(1'b0, `SSI_OFF_INT_ENABLE, 32'h0000_0000, 4'hF, r);
    chk("enable", m_ien, r);
    wb(1'b0, `SSI_OFF_INT_STATUS, 32'h0000_0000, 4'hF, r);
    chk("int_status", m_ist, r);
    wb(1'b0, `SSI_OFF_SEC_STATUS, 32'h0000_0000, 4'hF, r);
    chk("sec_status", m_sec | {26'h0, vertical_gate_i, line_gate_i, 4'h0}, r);
    wb(1'b0, `SSI_OFF_PRI_STATUS, 32'h0000_0000, 4'hF, r);
    chk("pri_status", ((m_sec & 15) != 0) ? 32'h0000_0004 : 32'h0000_0000, r);
    wb(1'b0, 32'h0000_0200, 32'h0000_0000, 4'hF, r);
    chk("unmapped", 32'h0000_0000, r);
    @(negedge clk_i);
    chk("combined", {31'h0, (m_sec & 15) != 0}, {31'h0, combined_counter_status_o});
    chk("irq", {31'h0, (m_ist & m_ien) != 0}, {31'h0, irq_o});
  endtask

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    $display("unexpected run_length expected finish seen timeout");
    close_out();
  end

  // Main sequence
  initial begin
    void'($urandom(32'h51b5_dfac));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    check_all();
    $display("test reset done");
    repeat (8) begin
      wr(`SSI_OFF_INT_ENABLE, $urandom, 4'($urandom));
      wr(32'h0000_0200, $urandom, 4'hF);
      wr(`SSI_OFF_SEC_STATUS, $urandom, 4'hF);
      check_all();
    end
    $display("test enable done");
    for (int i = 0; i < 6; i++) begin
      ev(6'(1 << i), 6'h00, 4'h0, 32'h0000_0000);
      check_all();
      ev(6'h00, 6'(1 << i), 4'h0, 32'h0000_0000);
      check_all();
      ev(6'(1 << i), 6'(1 << i), 4'h0, 32'h0000_0000);
      wr(`SSI_OFF_INT_STATUS, 32'h0000_0A00, 4'($urandom));
      check_all();
    end
    $display("test fifo flags done");
    repeat (4) begin
      @(posedge clk_i);
      vertical_gate_i <= 1'($urandom);
      line_gate_i <= 1'($urandom);
      check_all();
    end
    $display("test gates done");
    for (int i = 0; i < 4; i++) begin
      ev(6'h00, 6'h3F, 4'(1 << i), 32'h0000_0000);
      check_all();
      wr(`SSI_OFF_INT_STATUS, 32'h0000_0004, 4'hE);
      check_all();
      wr(`SSI_OFF_INT_STATUS, 32'h0000_0004, 4'h1);
      check_all();
    end
    $display("test counters done");
    // Events held across a write-one clear: the set must win
    @(posedge clk_i);
    fifo_err_i <= 6'h01;
    cnt_hit_i <= 4'h8;
    wr(`SSI_OFF_INT_STATUS, 32'h0000_0804, 4'hF);
    fifo_err_i <= '0;
    cnt_hit_i <= '0;
    m_sec = m_sec | 32'h0000_0088;
    m_ist = m_ist | 32'h0000_0804;
    check_all();
    $display("test set wins done");
    repeat (6) begin
      v = $urandom | 32'h8000_0000;
      ev(6'($urandom), 6'h00, 4'($urandom), v);
      wr(`SSI_OFF_INT_ENABLE, $urandom | 32'h8000_0000, 4'hF);
      check_all();
      wr(`SSI_OFF_INT_STATUS, $urandom, 4'hF);
      check_all();
    end
    wr(`SSI_OFF_INT_STATUS, 32'hFFFF_FFFF, 4'hF);
    check_all();
    $display("test irq done");
    close_out();
  end
endmodule
